//--- src/minmax_limit_checker.sv
// min/max statistics and HI/LO/PASS limit check with AXI4-Lite registers
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - program key then 5 starts min/max mode, then 6 starts limit mode
// - function, range and zero writes are ignored while a mode is active
// - min/max entry: program number, message, each half a second, then live
// - live readings shown; minimum and maximum updated automatically
// - extremes stored at full precision regardless of display resolution
// - recalled extremes at full precision only in six-and-a-half digit mode
// - first recall: program number, low tag, half second each, then minimum
// - second recall: high tag half a second, then the maximum
// - program 1 or 2 during playback aborts the playback
// - confirm after playback resumes live tracking, extremes kept
// - extremes cleared only when min/max mode is entered anew
// - limit entry: program number, low prompt half second, old low limit
// - low limit keyed digit by digit within full count and range
// - after low confirm: high prompt half second, old high limit
// - high limit within full count and range
// - check starts only if high limit exceeds low limit
// - running check shows LO, HI or PASS, no number
// - recall during check returns to the low-limit prompt
// - three open-collector outputs mark HI, LO and PASS
module minmax_limit_checker import minmax_pkg::*; #(
  parameter int HALF_CYC = HALF_SEC_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic keyValid,
  input wire logic [3:0] keyCode,
  input wire logic rdValid,
  input wire logic signed [VAL_W-1:0] rdValue,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output disp_t dispCode,
  output logic signed [VAL_W-1:0] dispValue,
  output logic [3:0] dispProg,
  output logic [2:0] dpPos,
  output logic [SET_W-1:0] settings,
  output logic ocHiOe,
  output logic ocLoOe,
  output logic ocPassOe
);
  localparam int CNT_W = $clog2(HALF_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYC - 1);

  if (HALF_CYC < 1) begin : g_chk
    $error("half second must be at least one cycle");
  end

  state_t state_ff;
  state_t nxtState;
  logic [CNT_W-1:0] halfCnt_ff;
  logic halfDone;
  logic timed;
  logic res6_ff;
  logic modeActive_ff;
  logic refused_ff;
  logic resValid_ff;
  logic signed [VAL_W-1:0] lowLim_ff;
  logic signed [VAL_W-1:0] highLim_ff;
  logic [VAL_W-1:0] rangeMax_ff;
  logic [VAL_W-1:0] entryMag_ff;
  logic entryNeg_ff;
  logic entryFresh_ff;
  logic signed [VAL_W-1:0] entryVal;
  logic [VAL_W+3:0] shiftMag;
  logic entryOk;
  logic keyDigit;
  logic keyProg;
  logic keyConf;
  logic keyRecall;
  logic keyMinus;
  logic entering;
  logic signed [VAL_W-1:0] minVal;
  logic signed [VAL_W-1:0] maxVal;
  logic haveFirst;
  logic awHeld_ff;
  logic wHeld_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic doWrite;
  logic [31:0] wMask;
  logic [31:0] rdMux;
  logic rdHit;

  assign keyDigit = keyValid && keyCode <= KEY_MAX_DIGIT;
  assign keyProg = keyValid && keyCode == KEY_PROG;
  assign keyConf = keyValid && keyCode == KEY_CONFIRM;
  assign keyRecall = keyValid && keyCode == KEY_RECALL;
  assign keyMinus = keyValid && keyCode == KEY_MINUS;
  assign entering = nxtState != state_ff;
  assign halfDone = halfCnt_ff == CNT_LAST;
  assign timed = state_ff inside {ST_MM_NUM, ST_MM_MSG, ST_MM_RPRG, ST_MM_LOTAG, ST_MM_HITAG,
                                  ST_LM_NUM, ST_LM_LOP, ST_LM_HIP};
  assign entryVal = entryNeg_ff ? -$signed(entryMag_ff) : $signed(entryMag_ff);
  assign shiftMag = (VAL_W+4)'(entryMag_ff) * (VAL_W+4)'(10) + (VAL_W+4)'(keyCode);
  // limits may not exceed the full count nor the range in use
  assign entryOk = entryMag_ff <= rangeMax_ff && entryMag_ff <= FULL_COUNT;

  // sequencer; keys are ignored during the timed messages so that each lasts exactly half a second
  always_comb begin
    nxtState = state_ff;
    if (timed) begin
      if (halfDone) begin
        unique case (state_ff)
          ST_MM_NUM: nxtState = ST_MM_MSG;
          ST_MM_MSG: nxtState = ST_MM_LIVE;
          ST_MM_RPRG: nxtState = ST_MM_LOTAG;
          ST_MM_LOTAG: nxtState = ST_MM_SHOWLO;
          ST_MM_HITAG: nxtState = ST_MM_SHOWHI;
          ST_LM_NUM: nxtState = ST_LM_LOP;
          ST_LM_LOP: nxtState = ST_LM_LOENT;
          default: nxtState = ST_LM_HIENT;
        endcase
      end
    end else if (keyProg && state_ff != ST_PSEL) begin
      nxtState = ST_PSEL;
    end else begin
      unique case (state_ff)
        ST_PSEL: begin
          if (keyDigit) begin
            // any program other than 5 or 6 leaves, which also aborts playback
            nxtState = keyCode == PRG_MINMAX ? ST_MM_NUM : keyCode == PRG_LIMIT ? ST_LM_NUM : ST_IDLE;
          end
        end
        ST_MM_LIVE: if (keyRecall) nxtState = ST_MM_RPRG;
        ST_MM_SHOWLO: begin
          if (keyRecall) begin
            nxtState = ST_MM_HITAG;
          end else if (keyConf) begin
            nxtState = ST_MM_LIVE;
          end
        end
        ST_MM_SHOWHI: if (keyConf) nxtState = ST_MM_LIVE;
        ST_LM_LOENT: if (keyConf && entryOk) nxtState = ST_LM_HIP;
        ST_LM_HIENT: if (keyConf && entryOk && entryVal > lowLim_ff) nxtState = ST_LM_RUN;
        ST_LM_RUN: if (keyRecall) nxtState = ST_LM_LOP;
        default: nxtState = state_ff;
      endcase
    end
  end

  // state register and half-second timer, restarted on every state change
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      halfCnt_ff <= '0;
    end else if (ce) begin
      state_ff <= nxtState;
      halfCnt_ff <= (entering || !timed) ? '0 : halfCnt_ff + 1'b1;
    end
  end

  // a mode counts as active from its entry until the program is left
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      modeActive_ff <= 1'b0;
    end else if (ce) begin
      if (nxtState inside {ST_MM_NUM, ST_LM_NUM}) begin
        modeActive_ff <= 1'b1;
      end else if (nxtState == ST_IDLE) begin
        modeActive_ff <= 1'b0;
      end
    end
  end

  // limit entry: old value loaded, first digit replaces it, overlong digits dropped
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      entryMag_ff <= '0;
      entryNeg_ff <= 1'b0;
      entryFresh_ff <= 1'b1;
    end else if (ce) begin
      if (entering && nxtState inside {ST_LM_LOENT, ST_LM_HIENT}) begin
        entryNeg_ff <= nxtState == ST_LM_LOENT ? lowLim_ff[VAL_W-1] : highLim_ff[VAL_W-1];
        entryMag_ff <= nxtState == ST_LM_LOENT ? VAL_W'(lowLim_ff[VAL_W-1] ? -lowLim_ff : lowLim_ff)
                                               : VAL_W'(highLim_ff[VAL_W-1] ? -highLim_ff : highLim_ff);
        entryFresh_ff <= 1'b1;
      end else if (state_ff inside {ST_LM_LOENT, ST_LM_HIENT}) begin
        if (keyDigit && entryFresh_ff) begin
          entryMag_ff <= VAL_W'(keyCode);
          entryFresh_ff <= 1'b0;
        end else if (keyDigit && shiftMag <= (VAL_W+4)'(FULL_COUNT)) begin
          entryMag_ff <= VAL_W'(shiftMag);
        end else if (keyMinus) begin
          entryNeg_ff <= !entryNeg_ff;
          entryFresh_ff <= 1'b0;
        end
      end
    end
  end

  // stored limits and the refusal flag; limits persist across runs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lowLim_ff <= '0;
      highLim_ff <= '0;
      refused_ff <= 1'b0;
    end else if (ce) begin
      if (state_ff == ST_LM_LOENT && nxtState == ST_LM_HIP) begin
        lowLim_ff <= entryVal;
      end
      if (state_ff == ST_LM_HIENT && keyConf) begin
        refused_ff <= nxtState != ST_LM_RUN;
      end
      if (state_ff == ST_LM_HIENT && nxtState == ST_LM_RUN) begin
        highLim_ff <= entryVal;
      end
    end
  end

  // classification; a reading equal to a limit passes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ocLoOe <= 1'b0;
      ocHiOe <= 1'b0;
      ocPassOe <= 1'b0;
      resValid_ff <= 1'b0;
    end else if (ce) begin
      if (state_ff != ST_LM_RUN) begin
        ocLoOe <= 1'b0;
        ocHiOe <= 1'b0;
        ocPassOe <= 1'b0;
        resValid_ff <= 1'b0;
      end else if (rdValid) begin
        ocLoOe <= rdValue < lowLim_ff;
        ocHiOe <= rdValue > highLim_ff;
        ocPassOe <= rdValue >= lowLim_ff && rdValue <= highLim_ff;
        resValid_ff <= 1'b1;
      end
    end
  end

  minmax_tracker #(.W(VAL_W)) u_track (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .clear(state_ff == ST_PSEL && nxtState == ST_MM_NUM),
    .sampleEn(rdValid && state_ff inside {ST_MM_NUM, ST_MM_MSG, ST_MM_LIVE}),
    .sample(rdValue),
    .minVal(minVal),
    .maxVal(maxVal),
    .haveFirst(haveFirst)
  );

  // display; 5.5 digit mode drops the last digit of live and recalled values
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dispCode <= DSP_BLANK;
      dispValue <= '0;
      dispProg <= '0;
      dpPos <= '0;
    end else if (ce) begin
      dpPos <= settings[RANGE_LSB +: 3];
      dispProg <= state_ff inside {ST_LM_NUM, ST_LM_LOP, ST_LM_LOENT, ST_LM_HIP, ST_LM_HIENT, ST_LM_RUN}
                  ? PRG_LIMIT : PRG_MINMAX;
      unique case (state_ff)
        ST_IDLE, ST_MM_LIVE: dispCode <= DSP_READING;
        ST_PSEL: dispCode <= DSP_PROMPT;
        ST_MM_NUM, ST_LM_NUM, ST_MM_RPRG: dispCode <= DSP_PRGNUM;
        ST_MM_MSG: dispCode <= DSP_MSG;
        ST_MM_LOTAG: dispCode <= DSP_LOTAG;
        ST_MM_HITAG: dispCode <= DSP_HITAG;
        ST_MM_SHOWLO, ST_MM_SHOWHI: dispCode <= DSP_VALUE;
        ST_LM_LOP: dispCode <= DSP_LOLPROMPT;
        ST_LM_HIP: dispCode <= DSP_HILPROMPT;
        ST_LM_LOENT, ST_LM_HIENT: dispCode <= DSP_ENTRY;
        default: dispCode <= !resValid_ff ? DSP_BLANK : ocLoOe ? DSP_LO : ocHiOe ? DSP_HI : DSP_PASS;
      endcase
      if (state_ff inside {ST_LM_LOENT, ST_LM_HIENT}) begin
        dispValue <= entryVal;
      end else if (state_ff == ST_LM_RUN) begin
        dispValue <= '0;
      end else begin
        dispValue <= res6_ff ? (state_ff == ST_MM_SHOWLO ? minVal : state_ff == ST_MM_SHOWHI ? maxVal : rdValue)
                             : ((state_ff == ST_MM_SHOWLO ? minVal : state_ff == ST_MM_SHOWHI ? maxVal : rdValue)
                                / 24'sd10) * 24'sd10;
      end
    end
  end

  // byte lanes of the write strobe
  always_comb begin
    wMask = '0;
    for (int b = 0; b < 4; b++) begin
      wMask[b*8 +: 8] = {8{wStrb_ff[b]}};
    end
  end
  assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;

  // write channel: address and data accepted in either order
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= '0;
      wStrb_ff <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_ff <= s_axi_awaddr;
        awHeld_ff <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
        wHeld_ff <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= awAddr_ff inside {ADDR_CTRL, ADDR_RANGEMAX} ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // writable registers; resolution stays free, settings freeze inside a mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      settings <= SET_RST;
      res6_ff <= RES6_RST;
      rangeMax_ff <= FULL_COUNT;
    end else if (ce && doWrite) begin
      if (awAddr_ff == ADDR_CTRL && wStrb_ff[0]) begin
        res6_ff <= wData_ff[RES6_BIT];
        if (!modeActive_ff) begin
          settings <= wData_ff[SET_W-1:0];
        end
      end
      if (awAddr_ff == ADDR_RANGEMAX) begin
        rangeMax_ff <= (rangeMax_ff & ~wMask[VAL_W-1:0]) | (wData_ff[VAL_W-1:0] & wMask[VAL_W-1:0]);
      end
    end
  end

  // read mux; unmapped addresses answer SLVERR with zero data
  always_comb begin
    rdHit = 1'b1;
    rdMux = '0;
    unique case (s_axi_araddr)
      ADDR_CTRL: rdMux = {25'h0, res6_ff, settings};
      ADDR_STATUS: begin
        rdMux[3:0] = state_ff;
        rdMux[ST_ACTIVE_BIT] = modeActive_ff;
        rdMux[ST_REFUSED_BIT] = refused_ff;
        rdMux[ST_LO_BIT] = ocLoOe;
        rdMux[ST_HI_BIT] = ocHiOe;
        rdMux[ST_PASS_BIT] = ocPassOe;
      end
      ADDR_MIN: rdMux = 32'(minVal);
      ADDR_MAX: rdMux = 32'(maxVal);
      ADDR_LOWLIM: rdMux = 32'(lowLim_ff);
      ADDR_HIGHLIM: rdMux = 32'(highLim_ff);
      ADDR_RANGEMAX: rdMux = {8'h00, rangeMax_ff};
      default: rdHit = 1'b0;
    endcase
  end

  // read channel: one outstanding read, data registered
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence mmStart;
    ce && state_ff == ST_PSEL && keyDigit && keyCode == PRG_MINMAX;
  endsequence
  sequence lmStart;
    ce && state_ff == ST_PSEL && keyDigit && keyCode == PRG_LIMIT;
  endsequence

  minmax_entry_a: assert property (mmStart |=> state_ff == ST_MM_NUM ##0 !haveFirst)
    else $error("min/max entry not taken");
  limit_entry_a: assert property (lmStart |=> state_ff == ST_LM_NUM ##0 modeActive_ff)
    else $error("limit entry not taken");
  settings_lock_a: assert property (modeActive_ff |=> settings == $past(settings))
    else $error("settings changed inside a mode");
  half_second_a: assert property (timed && ce && entering |-> halfCnt_ff == CNT_LAST)
    else $error("timed message left early");
  msg_follow_a: assert property (ce && state_ff == ST_MM_NUM && entering |=> state_ff == ST_MM_MSG)
    else $error("message does not follow program number");
  abort_play_a: assert property (ce && state_ff == ST_PSEL && keyDigit && keyCode inside {4'h1, 4'h2}
                                 |=> state_ff == ST_IDLE ##1 dispCode == DSP_READING)
    else $error("playback not aborted");
  resume_live_a: assert property (ce && state_ff == ST_MM_SHOWHI && keyConf && !keyProg
                                  |=> state_ff == ST_MM_LIVE && $stable(minVal) && $stable(maxVal))
    else $error("resume lost extremes");
  high_refuse_a: assert property (ce && state_ff == ST_LM_HIENT && keyConf && entryVal <= lowLim_ff
                                  |=> state_ff != ST_LM_RUN && refused_ff)
    else $error("bad limits accepted");
  recall_limit_a: assert property (ce && state_ff == ST_LM_RUN && keyRecall && !keyProg |=> state_ff == ST_LM_LOP)
    else $error("recall did not restart limits");
  one_result_a: assert property ($onehot0({ocLoOe, ocHiOe, ocPassOe})
                                 && (!resValid_ff || $onehot({ocLoOe, ocHiOe, ocPassOe})))
    else $error("result outputs not exclusive");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule // minmax_limit_checker

//--- src/minmax_pkg.sv
// shared constants and types for the min/max and limit checker
package minmax_pkg;
  localparam int VAL_W = 24;
  localparam int ADDR_W = 5;
  localparam int CLK_HZ = 20000000;
  localparam int HALF_SEC_MS = 500;
  localparam int HALF_SEC_CYC = CLK_HZ / 1000 * HALF_SEC_MS;
  localparam logic [VAL_W-1:0] FULL_COUNT = 24'h1e847f;
  // key codes on the keypad event port
  localparam logic [3:0] KEY_MAX_DIGIT = 4'h9;
  localparam logic [3:0] KEY_PROG = 4'ha;
  localparam logic [3:0] KEY_CONFIRM = 4'hb;
  localparam logic [3:0] KEY_RECALL = 4'hc;
  localparam logic [3:0] KEY_MINUS = 4'hd;
  localparam logic [3:0] PRG_MINMAX = 4'h5;
  localparam logic [3:0] PRG_LIMIT = 4'h6;
  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_MIN = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 5'h0c;
  localparam logic [ADDR_W-1:0] ADDR_LOWLIM = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_HIGHLIM = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_RANGEMAX = 5'h18;
  // control fields: function, range, zero, resolution
  localparam int SET_W = 6;
  localparam int RANGE_LSB = 2;
  localparam int RES6_BIT = 6;
  localparam logic [SET_W-1:0] SET_RST = 6'h00;
  localparam logic RES6_RST = 1'b1;
  // status fields
  localparam int ST_ACTIVE_BIT = 4;
  localparam int ST_REFUSED_BIT = 5;
  localparam int ST_LO_BIT = 6;
  localparam int ST_HI_BIT = 7;
  localparam int ST_PASS_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_PSEL = 4'h1, ST_MM_NUM = 4'h2, ST_MM_MSG = 4'h3,
    ST_MM_LIVE = 4'h4, ST_MM_RPRG = 4'h5, ST_MM_LOTAG = 4'h6, ST_MM_SHOWLO = 4'h7,
    ST_MM_HITAG = 4'h8, ST_MM_SHOWHI = 4'h9, ST_LM_NUM = 4'ha, ST_LM_LOP = 4'hb,
    ST_LM_LOENT = 4'hc, ST_LM_HIP = 4'hd, ST_LM_HIENT = 4'he, ST_LM_RUN = 4'hf
  } state_t;

  typedef enum logic [3:0] {
    DSP_READING = 4'h0, DSP_PROMPT = 4'h1, DSP_PRGNUM = 4'h2, DSP_MSG = 4'h3,
    DSP_LOTAG = 4'h4, DSP_HITAG = 4'h5, DSP_VALUE = 4'h6, DSP_LOLPROMPT = 4'h7,
    DSP_HILPROMPT = 4'h8, DSP_ENTRY = 4'h9, DSP_LO = 4'ha, DSP_HI = 4'hb,
    DSP_PASS = 4'hc, DSP_BLANK = 4'hd
  } disp_t;
endpackage

//--- src/minmax_tracker.sv
// running minimum and maximum of signed readings
`timescale 1ns/1ps
module minmax_tracker import minmax_pkg::*; #(
  parameter int W = VAL_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic sampleEn,
  input wire logic signed [W-1:0] sample,
  output logic signed [W-1:0] minVal,
  output logic signed [W-1:0] maxVal,
  output logic haveFirst
);
  if (W < 22) begin : g_chk
    $error("reading width too small for full count");
  end

  // extremes keep full precision whatever the display shows
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      minVal <= '0;
      maxVal <= '0;
      haveFirst <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        haveFirst <= 1'b0;
      end else if (sampleEn) begin
        haveFirst <= 1'b1;
        if (!haveFirst || sample < minVal) begin
          minVal <= sample;
        end
        if (!haveFirst || sample > maxVal) begin
          maxVal <= sample;
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  order_kept_a: assert property (haveFirst |-> minVal <= maxVal)
    else $error("minimum above maximum");
  first_load_a: assert property (ce && !clear && sampleEn && !haveFirst |=> minVal == maxVal)
    else $error("first reading not loaded into both extremes");
endmodule // minmax_tracker

//--- verification/keypad_model.sv
// operator keypad model: turns a press request into the one-cycle key event
`timescale 1ns/1ps
module keypad_model (
  input wire logic clk_sys,
  input wire logic pressGo,
  input wire logic [3:0] pressCode,
  output logic keyValid,
  output logic [3:0] keyCode
);
  initial begin
    keyValid = 1'b0;
    keyCode = 4'h0;
  end
  // one digit per press; the code is inverted between presses so a stale code never looks valid
  always @(posedge clk_sys) begin
    keyValid <= pressGo;
    keyCode <= pressGo ? pressCode : ~keyCode;
  end
endmodule // keypad_model

//--- verification/minmax_limit_checker_tb.sv
// self-checking bench for the min/max and limit checker
`timescale 1ns/1ps
module minmax_limit_checker_tb;
  import minmax_pkg::*;
  localparam int HC = 4;
  logic clk_sys = 0, rst_n = 0, ce = 1, pressGo = 0, rdValid = 0, keyValid, ocHiOe, ocLoOe, ocPassOe;
  logic [3:0] pressCode = 4'h0, keyCode, dispProg;
  logic signed [VAL_W-1:0] rdValue = 24'h0, dispValue;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] dpPos;
  logic [SET_W-1:0] settings;
  disp_t dispCode;
  int errors = 0, n_checks = 0;
  // short half-second so each timed step is a handful of cycles
  minmax_limit_checker #(.HALF_CYC(HC)) uut (.clk_sys, .rst_n, .ce, .keyValid, .keyCode, .rdValid, .rdValue,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .dispCode, .dispValue, .dispProg, .dpPos, .settings,
    .ocHiOe, .ocLoOe, .ocPassOe);
  keypad_model kp (.clk_sys, .pressGo, .pressCode, .keyValid, .keyCode);
  initial forever #25 clk_sys = ~clk_sys;
  task automatic report_and_stop();
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic key(input logic [3:0] c);
    pressGo <= 1'b1;
    pressCode <= c;
    tick(1);
    pressGo <= 1'b0;
    tick(3);
  endtask
  task automatic rd(input logic [VAL_W-1:0] v);
    rdValid <= 1'b1;
    rdValue <= v;
    tick(1);
    rdValid <= 1'b0;
    tick(3);
  endtask
  // bounded wait for a display content; running out ends the run
  task automatic waitDisp(input disp_t c);
    int i;
    for (i = 0; i < 100 && dispCode !== c; i++) tick(1);
    if (i == 100) begin
      errors++;
      report_and_stop();
    end
  endtask
  // handshakes judged at the falling edge, where the values the next rising edge samples are settled
  task automatic axw(input logic [4:0] a, input logic [31:0] v);
    int i;
    logic ta, tw, tb;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge clk_sys);
      {ta, tw, tb, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 50) begin
      errors++;
      report_and_stop();
    end
    tick(1);
  endtask
  task automatic axr(input logic [4:0] a);
    int i;
    logic ta, tb;
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge clk_sys);
      {ta, tb, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tb) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 50) begin
      errors++;
      report_and_stop();
    end
    tick(1);
  endtask
  // min/max run, 5.5 digits from the control write on: recall truncates, registers keep full precision
  task automatic minmax_run();
    key(KEY_PROG);
    key(PRG_MINMAX);
    waitDisp(DSP_PRGNUM);
    chk(dispProg, 32'h5);
    waitDisp(DSP_MSG);
    waitDisp(DSP_READING);
    rd(24'h64);
    chk(dispValue, 32'h64);
    rd(24'hffffc7);
    rd(24'h12f);
    axw(ADDR_CTRL, 32'h1c);
    chk(r, RESP_OKAY);
    chk(settings, 32'h0);
    key(KEY_RECALL);
    chk(dispCode, DSP_PRGNUM);
    waitDisp(DSP_LOTAG);
    waitDisp(DSP_VALUE);
    chk(dispValue, 32'hffffffce);
    key(KEY_RECALL);
    waitDisp(DSP_HITAG);
    waitDisp(DSP_VALUE);
    chk(dispValue, 32'h12c);
    key(KEY_CONFIRM);
    waitDisp(DSP_READING);
    // clock enable low: this reading must leave the extremes untouched
    ce <= 1'b0;
    rd(24'hffff00);
    ce <= 1'b1;
    rd(24'ha);
    axr(ADDR_MIN);
    chk(d, 32'hffffffc7);
    axr(ADDR_MAX);
    chk(d, 32'h12f);
    key(KEY_RECALL);
    waitDisp(DSP_VALUE);
    key(KEY_PROG);
    key(4'h1);
    axr(ADDR_STATUS);
    chk(d[4], 32'h0);
    chk(d[3:0], ST_IDLE);
  endtask
  // limits 10..20, edge readings, then re-entry with a refused high limit
  task automatic limit_run();
    axw(ADDR_CTRL, 32'h4c);
    chk(settings, 32'hc);
    key(KEY_PROG);
    key(PRG_LIMIT);
    waitDisp(DSP_LOLPROMPT);
    chk(dispProg, 32'h6);
    chk(dpPos, 32'h3);
    waitDisp(DSP_ENTRY);
    chk(dispValue, 32'h0);
    key(4'h1);
    key(4'h0);
    chk(dispValue, 32'ha);
    key(KEY_CONFIRM);
    waitDisp(DSP_HILPROMPT);
    waitDisp(DSP_ENTRY);
    key(4'h2);
    key(4'h0);
    key(KEY_CONFIRM);
    rd(24'h9);
    chk({ocHiOe, ocLoOe, ocPassOe, dispCode}, {3'b010, DSP_LO});
    rd(24'h14);
    chk({ocHiOe, ocLoOe, ocPassOe, dispCode}, {3'b001, DSP_PASS});
    rd(24'h15);
    chk({ocHiOe, ocLoOe, ocPassOe, dispCode}, {3'b100, DSP_HI});
    chk(dispValue, 32'h0);
    key(KEY_RECALL);
    waitDisp(DSP_LOLPROMPT);
    waitDisp(DSP_ENTRY);
    key(KEY_CONFIRM);
    waitDisp(DSP_ENTRY);
    key(4'h5);
    key(KEY_CONFIRM);
    axr(ADDR_STATUS);
    chk(d[5], 32'h1);
    // entry 50 fits the full count but not a 49-count range: refused until the range allows it
    axw(ADDR_RANGEMAX, 32'h31);
    key(4'h0);
    key(KEY_CONFIRM);
    axr(ADDR_STATUS);
    chk(d[3:0], ST_LM_HIENT);
    axw(ADDR_RANGEMAX, 32'h32);
    chk(r, RESP_OKAY);
    key(KEY_CONFIRM);
    axr(ADDR_STATUS);
    chk(d[3:0], ST_LM_RUN);
    axr(5'h1c);
    chk(r, RESP_SLVERR);
  endtask
  initial begin
    tick(6);
    rst_n <= 1'b1;
    tick(1);
    minmax_run();
    limit_run();
    report_and_stop();
  end
endmodule // minmax_limit_checker_tb
